// ---- actc_params.svh ----
// Constants for the actuator control block: register offsets, reset
// values, field positions and timing counts.
// Assumes a 100 MHz core clock; offsets are register indices on the
// register port.
`ifndef ACTC_PARAMS_SVH
`define ACTC_PARAMS_SVH

// Register offsets
`define ACTC_ADDR_DEMAND    16'h9c41
`define ACTC_ADDR_CAL       16'h9c43
`define ACTC_ADDR_LOWCAP    16'h9c44
`define ACTC_ADDR_HIGHCAP   16'h9c45
`define ACTC_ADDR_READING   16'h9c59
`define ACTC_ADDR_SRC       16'h9c62
`define ACTC_ADDR_LOS       16'h9c63
`define ACTC_ADDR_DEADBAND  16'h9c64
`define ACTC_ADDR_CUTOFF    16'h9c65
`define ACTC_ADDR_MODE      16'h9c6b
`define ACTC_ADDR_STATION   16'h9c80
`define ACTC_ADDR_BAUD      16'h9c81
`define ACTC_ADDR_PARITY    16'h9c82
`define ACTC_ADDR_STOP      16'h9c83
`define ACTC_ADDR_STATUS    16'h9c84

// Reset values
`define ACTC_RST_SRC        16'h0001
`define ACTC_RST_LOS        16'h0000
`define ACTC_RST_CUTOFF     16'h0005
`define ACTC_RST_DEADBAND   16'h0002
`define ACTC_RST_MODE       16'h0000
`define ACTC_RST_STATION    16'h0001
`define ACTC_RST_BAUD       16'h2580
`define ACTC_RST_PARITY     16'h0002
`define ACTC_RST_STOP       16'h0001
`define ACTC_RST_LOW_EP     16'h2000
`define ACTC_RST_HIGH_EP    16'he000

// Values and fields
`define ACTC_TRIGGER        16'h0001
`define ACTC_ONOFF_SPLIT    16'h0032
`define ACTC_PCT_FULL       7'h64
`define ACTC_STAT_FAULT     0
`define ACTC_STAT_BUSY      1
`define ACTC_STAT_WINDOW    2

// Timing
`define ACTC_CLK_HZ         100000000
`define ACTC_PU_WINDOW_S    15
`define ACTC_PU_WINDOW_CYC  (`ACTC_PU_WINDOW_S * `ACTC_CLK_HZ)
`define ACTC_STALL_MS       500
`define ACTC_STALL_CYC      (`ACTC_STALL_MS * (`ACTC_CLK_HZ / 1000))

`endif

// ---- actc_pkg.sv ----
// Types shared by the actuator control block.
// Assumes nothing beyond a SystemVerilog compiler.
package actc_pkg;

  typedef enum logic [1:0] {CAL_IDLE, CAL_OPEN, CAL_CLOSE} actc_cal_t;
  typedef enum logic [1:0] {PU_WAIT, PU_ARMED, PU_DONE} actc_pu_t;

  typedef struct packed {
    logic [15:0] demand, src, los, deadband, cutoff, mode;
    logic [15:0] station, baud, parity, stop, low_ep, high_ep, rdata;
    logic        ack, err;
    logic [6:0]  target, stall_ref, dual_last;
    actc_cal_t   cal;
    actc_pu_t    pu;
    logic [31:0] pu_cnt;
    logic        fault, retry, cal_req, busy;
  } actc_state_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic [6:0]  last;
    logic        stalled, stall, open, close;
  } actc_motor_t;

  typedef struct packed {
    logic [6:0] pct;
  } actc_scale_t;

endpackage

// ---- actc_motion_if.sv ----
// Motion request and stall report between control and motor drive.
// Assumes both ends sit on the same core clock.
interface actc_motion_if;
  logic [6:0] target;
  logic       enable;
  logic       retry;
  logic       stall;
  logic       motor_open;
  logic       motor_close;

  modport ctrl  (output target, enable, retry,
                 input  stall, motor_open, motor_close);
  modport drive (input  target, enable, retry,
                 output stall, motor_open, motor_close);
endinterface

// ---- actc_scale.sv ----
// Linear map of the analog reading onto percent travel.
// Assumes the high endpoint lies above the low endpoint.
module actc_scale
  import actc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Reading and endpoints
  input  wire logic [15:0] reading,
  input  wire logic [15:0] low_ep,
  input  wire logic [15:0] high_ep,
  // Result
  output      logic [6:0]  pct
);
  actc_scale_t r_reg;
  actc_scale_t r_next;
  logic [31:0] prod;
  logic [31:0] span;

  always_comb begin
    r_next = r_reg;
    prod   = 32'({16'h0000, reading - low_ep}) * 32'h0000_0064;
    span   = {16'h0000, high_ep - low_ep};
    // Below the low endpoint means closed
    if (reading <= low_ep) begin
      r_next.pct = 7'h00;
    end else if (reading >= high_ep) begin
      r_next.pct = 7'h64;
    end else begin
      r_next.pct = 7'(prod / span);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pct = r_reg.pct;
endmodule

// ---- actc_motor.sv ----
// Motor drive toward the target with stall detection.
// Assumes position feedback in percent, 0 closed and 100 open.
`include "actc_params.svh"
module actc_motor
  import actc_pkg::*;
#(
  parameter int unsigned STALL_CYCLES = `ACTC_STALL_CYC
)
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Feedback
  input  wire logic [6:0] position_pct,
  // Control side
  actc_motion_if.drive    m
);
  actc_motor_t r_reg;
  actc_motor_t r_next;
  logic        mv_open;
  logic        mv_close;

  always_comb begin
    r_next       = r_reg;
    r_next.stall = 1'b0;
    r_next.last  = position_pct;
    if (m.retry) begin
      r_next.stalled = 1'b0;
    end
    mv_open  = m.enable && !r_reg.stalled && (position_pct < m.target);
    mv_close = m.enable && !r_reg.stalled && (position_pct > m.target);
    // No progress while driven for the whole timeout is a stall
    if (!(mv_open || mv_close) || position_pct != r_reg.last) begin
      r_next.cnt = 32'h0;
    end else if (r_reg.cnt >= STALL_CYCLES - 1) begin
      r_next.stalled = 1'b1;
      r_next.stall   = 1'b1;
      r_next.cnt     = 32'h0;
      mv_open        = 1'b0;
      mv_close       = 1'b0;
    end else begin
      r_next.cnt = r_reg.cnt + 32'h1;
    end
    r_next.open  = mv_open;
    r_next.close = mv_close;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign m.stall       = r_reg.stall;
  assign m.motor_open  = r_reg.open;
  assign m.motor_close = r_reg.close;
endmodule

// ---- actc_control.sv ----
// Control source selection, demand decoding, calibration and stall
// handling for the valve actuator controller.
// Assumes a serial slave outside that turns frames into register
// strobes, and an analog front end giving 0 when no input is seen.
`include "actc_params.svh"

// Overview of operation
// - Source register 0 follows demand register; 1 follows local inputs.
// - On/off unit: demand 0-49 closes fully, 50-100 opens fully.
// - Positioning unit: mode 0 means 1-5 V, mode 1 means 4-20 mA.
// - On/off unit: mode 0 is dual contact, mode 1 single contact.
// - Writing 1 to calibrate runs open, closed, then commanded position.
// - Local calibration sequence only accepted inside power-up window.
// - Dual contact: open contact arms silently, close contact calibrates.
// - Single contact: closing arms silently, opening then calibrates.
// - Analog: full scale arms silently, minimum scale calibrates.
// - Analog target linear, low endpoint closed, high endpoint open.
// - Endpoint capture writes store the present reading as 0% or 100%.
// - Register demand on positioning unit is percent travel, 0 to 100.
// - Open contact opens; dual close contact closes; single open closes.
// - Analog below the low endpoint commands closed.
// - Reading register shows present analog value, 0 with no input.
// - Failure to reach position stops motor and flags stall fault.
// - After stall, retry only when command moves beyond the deadband.
// - Link defaults 9600 baud even parity; master must match.
// - Loss of signal drives to the fail position register, default 0.
// - Low travel cutoff register, default 5 percent, forces closed.
// - Link defaults station 1, one stop bit, changeable by register.
module actc_control
  import actc_pkg::*;
#(
  parameter int unsigned PU_CYCLES    = `ACTC_PU_WINDOW_CYC,
  parameter int unsigned STALL_CYCLES = `ACTC_STALL_CYC
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  output      logic [15:0] reg_rdata,
  output      logic        reg_ack,
  output      logic        reg_err,
  // Local inputs
  input  wire logic [15:0] analog_code,
  input  wire logic        open_contact,
  input  wire logic        close_contact,
  input  wire logic        positioning_unit,
  input  wire logic [6:0]  position_pct,
  // Motor and status
  output      logic        motor_open,
  output      logic        motor_close,
  output      logic        stall_fault,
  output      logic        cal_busy,
  // Link settings
  output      logic [7:0]  link_station,
  output      logic [15:0] link_baud,
  output      logic [1:0]  link_parity,
  output      logic [1:0]  link_stop
);

  localparam actc_state_t ST_RST = '{
    src:      `ACTC_RST_SRC,
    los:      `ACTC_RST_LOS,
    deadband: `ACTC_RST_DEADBAND,
    cutoff:   `ACTC_RST_CUTOFF,
    mode:     `ACTC_RST_MODE,
    station:  `ACTC_RST_STATION,
    baud:     `ACTC_RST_BAUD,
    parity:   `ACTC_RST_PARITY,
    stop:     `ACTC_RST_STOP,
    low_ep:   `ACTC_RST_LOW_EP,
    high_ep:  `ACTC_RST_HIGH_EP,
    cal:      CAL_IDLE,
    pu:       PU_WAIT,
    default:  '0
  };

  actc_state_t s;
  actc_state_t s_next;
  actc_motion_if m_if ();

  logic       window;
  logic       hold;
  logic       lost;
  logic       arm;
  logic       fire;
  logic       retry_ok;
  logic [6:0] scaled;
  logic [6:0] loc_pct;
  logic [6:0] reg_pct;
  logic [6:0] dem;
  logic [6:0] dual_pct;

  function automatic logic [6:0] clip_pct(input logic [15:0] v);
    clip_pct = (v > 16'h0064) ? `ACTC_PCT_FULL : v[6:0];
  endfunction

  function automatic logic [6:0] abs_diff(input logic [6:0] a,
                                          input logic [6:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Submodules

  actc_scale u_scale (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .reading  (analog_code),
    .low_ep   (s.low_ep),
    .high_ep  (s.high_ep),
    .pct      (scaled)
  );

  actc_motor #(.STALL_CYCLES(STALL_CYCLES)) u_motor (
    .core_clk     (core_clk),
    .reset_n      (reset_n),
    .position_pct (position_pct),
    .m            (m_if)
  );

  ////////////////////////////////////////////////////////////////////
  // Demand decoding

  assign window = s.pu_cnt < PU_CYCLES;
  // Local source holds still until the power-up sequence is settled
  assign hold   = s.src[0] && (s.pu != PU_DONE);
  assign lost   = analog_code == 16'h0000;

  always_comb begin
    // Open contact has priority when both are closed
    if (open_contact) begin
      dual_pct = `ACTC_PCT_FULL;
    end else if (close_contact) begin
      dual_pct = 7'h00;
    end else begin
      dual_pct = s.dual_last;
    end
    if (positioning_unit) begin
      // Range choice only shifts the front end; codes map alike
      loc_pct = lost ? clip_pct(s.los) : scaled;
      reg_pct = clip_pct(s.demand);
    end else begin
      loc_pct = s.mode[0] ? (open_contact ? `ACTC_PCT_FULL : 7'h00)
                          : dual_pct;
      reg_pct = (s.demand >= `ACTC_ONOFF_SPLIT) ? `ACTC_PCT_FULL
                                                : 7'h00;
    end
    dem = s.src[0] ? loc_pct : reg_pct;
    if (positioning_unit && dem < clip_pct(s.cutoff)) begin
      dem = 7'h00;
    end
    retry_ok = abs_diff(dem, s.stall_ref) > clip_pct(s.deadband);
    // Power-up arm and fire conditions per input kind
    if (positioning_unit) begin
      arm  = analog_code >= s.high_ep;
      fire = !lost && analog_code <= s.low_ep;
    end else begin
      arm  = open_contact;
      fire = s.mode[0] ? !open_contact : close_contact;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next       = s;
    s_next.ack   = 1'b0;
    s_next.err   = 1'b0;
    s_next.retry = 1'b0;
    if (s.cal == CAL_IDLE) s_next.cal_req = 1'b0;
    if (window) begin
      s_next.pu_cnt = s.pu_cnt + 32'h1;
    end
    if (!positioning_unit) begin
      s_next.dual_last = dual_pct;
    end

    // Register writes
    if (reg_wr_en) begin
      s_next.ack = 1'b1;
      case (reg_addr)
        `ACTC_ADDR_DEMAND:   s_next.demand = reg_wdata;
        `ACTC_ADDR_CAL: begin
          if (reg_wdata == `ACTC_TRIGGER) s_next.cal_req = 1'b1;
        end
        `ACTC_ADDR_LOWCAP: begin
          if (reg_wdata == `ACTC_TRIGGER) s_next.low_ep = analog_code;
        end
        `ACTC_ADDR_HIGHCAP: begin
          if (reg_wdata == `ACTC_TRIGGER) s_next.high_ep = analog_code;
        end
        `ACTC_ADDR_SRC:      s_next.src = reg_wdata;
        `ACTC_ADDR_LOS:      s_next.los = reg_wdata;
        `ACTC_ADDR_DEADBAND: s_next.deadband = reg_wdata;
        `ACTC_ADDR_CUTOFF:   s_next.cutoff = reg_wdata;
        `ACTC_ADDR_MODE:     s_next.mode = reg_wdata;
        `ACTC_ADDR_STATION:  s_next.station = reg_wdata;
        `ACTC_ADDR_BAUD:     s_next.baud = reg_wdata;
        `ACTC_ADDR_PARITY:   s_next.parity = reg_wdata;
        `ACTC_ADDR_STOP:     s_next.stop = reg_wdata;
        `ACTC_ADDR_READING, `ACTC_ADDR_STATUS: ;
        default:             s_next.err = 1'b1;
      endcase
    end else if (reg_rd_en) begin
      s_next.ack   = 1'b1;
      s_next.rdata = 16'h0000;
      case (reg_addr)
        `ACTC_ADDR_DEMAND:   s_next.rdata = s.demand;
        `ACTC_ADDR_READING:  s_next.rdata = analog_code;
        `ACTC_ADDR_SRC:      s_next.rdata = s.src;
        `ACTC_ADDR_LOS:      s_next.rdata = s.los;
        `ACTC_ADDR_DEADBAND: s_next.rdata = s.deadband;
        `ACTC_ADDR_CUTOFF:   s_next.rdata = s.cutoff;
        `ACTC_ADDR_MODE:     s_next.rdata = s.mode;
        `ACTC_ADDR_STATION:  s_next.rdata = s.station;
        `ACTC_ADDR_BAUD:     s_next.rdata = s.baud;
        `ACTC_ADDR_PARITY:   s_next.rdata = s.parity;
        `ACTC_ADDR_STOP:     s_next.rdata = s.stop;
        `ACTC_ADDR_STATUS: begin
          s_next.rdata[`ACTC_STAT_FAULT]  = s.fault;
          s_next.rdata[`ACTC_STAT_BUSY]   = s.busy;
          s_next.rdata[`ACTC_STAT_WINDOW] = window;
        end
        // Triggers are write-only and read as zero
        `ACTC_ADDR_CAL, `ACTC_ADDR_LOWCAP, `ACTC_ADDR_HIGHCAP: ;
        default:             s_next.err = 1'b1;
      endcase
    end

    // Power-up local calibration sequence
    case (s.pu)
      PU_WAIT: begin
        if (!window || !s.src[0]) begin
          s_next.pu = PU_DONE;
        end else if (arm) begin
          s_next.pu = PU_ARMED;
        end
      end
      PU_ARMED: begin
        if (!window || !s.src[0]) begin
          s_next.pu = PU_DONE;
        end else if (fire) begin
          s_next.cal_req = 1'b1;
          s_next.pu      = PU_DONE;
        end
      end
      default: ;
    endcase

    // Calibration and target
    case (s.cal)
      CAL_IDLE: begin
        if (s.cal_req) begin
          s_next.cal     = CAL_OPEN;
          s_next.target  = `ACTC_PCT_FULL;
          s_next.retry   = 1'b1;
          s_next.fault   = 1'b0;
        end else if (!hold) begin
          if (!s.fault) begin
            s_next.target = dem;
          end else if (retry_ok) begin
            s_next.fault  = 1'b0;
            s_next.retry  = 1'b1;
            s_next.target = dem;
          end
        end
      end
      CAL_OPEN: begin
        // The end stop counts as reached on a stall too
        if (position_pct >= `ACTC_PCT_FULL || m_if.stall) begin
          s_next.cal    = CAL_CLOSE;
          s_next.target = 7'h00;
          s_next.retry  = 1'b1;
        end
      end
      CAL_CLOSE: begin
        if (position_pct == 7'h00 || m_if.stall) begin
          s_next.cal   = CAL_IDLE;
          s_next.retry = 1'b1;
        end
      end
      default: s_next.cal = CAL_IDLE;
    endcase

    // Stall sets the fault last so it wins over a clear
    if (m_if.stall && s.cal == CAL_IDLE) begin
      s_next.fault     = 1'b1;
      s_next.stall_ref = s.target;
    end
    s_next.busy = s_next.cal != CAL_IDLE;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s <= ST_RST;
    end else begin
      s <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign m_if.target  = s.target;
  assign m_if.enable  = !hold;
  assign m_if.retry   = s.retry;
  assign reg_rdata    = s.rdata;
  assign reg_ack      = s.ack;
  assign reg_err      = s.err;
  assign motor_open   = m_if.motor_open;
  assign motor_close  = m_if.motor_close;
  assign stall_fault  = s.fault;
  assign cal_busy     = s.busy;
  assign link_station = s.station[7:0];
  assign link_baud    = s.baud;
  assign link_parity  = s.parity[1:0];
  assign link_stop    = s.stop[1:0];

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  src_follow_a: assert property (
    (s.cal == CAL_IDLE && !s.cal_req && !hold && !s.fault && !s.src[0]
     && positioning_unit && s.demand <= 16'h0064
     && s.demand >= s.cutoff)
    |=> s.target == $past(s.demand[6:0]))
    else $error("target does not follow register demand");

  onoff_split_a: assert property (
    (s.cal == CAL_IDLE && !s.cal_req && !hold && !s.fault && !s.src[0]
     && !positioning_unit)
    |=> s.target == (($past(s.demand) >= 16'h0032) ? 7'h64 : 7'h00))
    else $error("on/off demand split wrong");

  cal_start_a: assert property (
    (reg_wr_en && reg_addr == `ACTC_ADDR_CAL && reg_wdata == 16'h0001
     && s.cal == CAL_IDLE && !s.cal_req)
    |-> ##2 (s.cal == CAL_OPEN && s.target == 7'h64 && cal_busy))
    else $error("calibration did not start");

  cal_close_a: assert property (
    (s.cal == CAL_OPEN && position_pct >= 7'h64)
    |=> s.cal == CAL_CLOSE && s.target == 7'h00)
    else $error("calibration close step wrong");

  low_cap_a: assert property (
    (reg_wr_en && reg_addr == `ACTC_ADDR_LOWCAP && reg_wdata == 16'h0001)
    |=> s.low_ep == $past(analog_code))
    else $error("low endpoint not captured");

  reading_a: assert property (
    (reg_rd_en && !reg_wr_en && reg_addr == `ACTC_ADDR_READING)
    |=> reg_ack && !reg_err && reg_rdata == $past(analog_code))
    else $error("reading register wrong");

  stall_stop_a: assert property (
    (m_if.stall && s.cal == CAL_IDLE)
    |-> (!motor_open && !motor_close) ##1 stall_fault)
    else $error("stall did not stop motor or flag fault");

  retry_band_a: assert property (
    ($fell(s.fault) && $past(s.cal) == CAL_IDLE && !$past(s.cal_req))
    |-> $past(retry_ok))
    else $error("retry inside deadband");

  pu_still_a: assert property (
    hold [*2] |-> (!motor_open && !motor_close))
    else $error("motion during power-up window");

  los_fail_a: assert property (
    (s.cal == CAL_IDLE && !s.cal_req && !hold && !s.fault && s.src[0]
     && positioning_unit && lost && s.los <= 16'h0064
     && s.los >= s.cutoff)
    |=> s.target == $past(s.los[6:0]))
    else $error("loss of signal position wrong");

  cal_run_c:  cover property (s.cal == CAL_OPEN ##[1:1000] s.cal == CAL_IDLE);
  stall_c:    cover property ($rose(stall_fault));
  pu_cal_c:   cover property (s.pu == PU_ARMED ##1 s.cal_req);
endmodule

// ---- actc_plant.sv ----
// Valve plug model for the bench: travel of one percent every 2nd cycle.
// Assumes the controller's motor outputs; jam freezes the plug.
module actc_plant (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Motor and fault injection
  input  wire logic       motor_open,
  input  wire logic       motor_close,
  input  wire logic       jam,
  // Feedback
  output      logic [6:0] position_pct
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph;
  always @(posedge core_clk) begin
    if (!reset_n) begin
      position_pct <= 7'h00;
      ph <= 1'b0;
    end else begin
      ph <= ~ph;
      // Jam stands for a blocked plug
      if (ph && !jam && motor_open && position_pct < 7'h64)
        position_pct <= position_pct + 7'h01;
      else if (ph && !jam && motor_close && position_pct > 7'h00)
        position_pct <= position_pct - 7'h01;
    end
  end
endmodule

// ---- testbench.sv ----
// Self-checking bench for the actuator controller.
// Assumes short counts: window 200 and stall 20 cycles.
`include "actc_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 0, reset_n = 0, jam = 0, pos_unit = 1;
  logic        open_c = 0, close_c = 0;
  logic [15:0] analog = 0;
  logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata, rd;
  logic        reg_wr_en = 0, reg_rd_en = 0, reg_ack, reg_err;
  logic        motor_open, motor_close, stall_fault, cal_busy;
  logic [6:0]  position_pct;
  int          n_errors = 0, n_compared = 0, i;
  logic [15:0] lf = 16'd6213;
  always #5 core_clk = ~core_clk;
  actc_control #(.PU_CYCLES(200), .STALL_CYCLES(20)) uut (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
    .analog_code(analog), .open_contact(open_c), .close_contact(close_c),
    .positioning_unit(pos_unit), .position_pct(position_pct),
    .motor_open(motor_open), .motor_close(motor_close),
    .stall_fault(stall_fault), .cal_busy(cal_busy), .link_station(),
    .link_baud(), .link_parity(), .link_stop());
  actc_plant plant (.core_clk(core_clk), .reset_n(reset_n), .jam(jam),
    .motor_open(motor_open), .motor_close(motor_close),
    .position_pct(position_pct));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One access; strobe held until the ack edge
  task automatic acc(input logic w, input logic [15:0] a, d,
                     input logic e_err);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = w;
    reg_rd_en = !w;
    @(negedge core_clk);
    reg_wr_en = 0;
    reg_rd_en = 0;
    rd = reg_rdata;
    chk({reg_ack, reg_err}, {1'b1, e_err});
  endtask
  // Expected travel from a register demand
  function automatic int model(input int d);
    if (!pos_unit) return d >= 50 ? 100 : 0;
    return d < 5 ? 0 : (d > 100 ? 100 : d);
  endfunction
  task automatic settle(input int exp);
    for (i = 0; i < 3000 && (position_pct !== exp[6:0] || motor_open ||
         motor_close); i++)
      @(negedge core_clk);
    chk({9'h0, position_pct}, exp[15:0]);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #500_000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(negedge core_clk);
    reset_n = 1;
    acc(0, `ACTC_ADDR_SRC, 0, 0);
    chk(rd, `ACTC_RST_SRC);
    acc(0, `ACTC_ADDR_DEADBAND, 0, 0);
    chk(rd, `ACTC_RST_DEADBAND);
    acc(0, `ACTC_ADDR_CUTOFF, 0, 0);
    chk(rd, `ACTC_RST_CUTOFF);
    acc(0, `ACTC_ADDR_BAUD, 0, 0);
    chk(rd, `ACTC_RST_BAUD);
    acc(0, `ACTC_ADDR_CAL, 0, 0);
    chk(rd, 16'h0000);
    acc(0, 16'h9c50, 0, 1);
    $display("test registers done");
    acc(1, `ACTC_ADDR_SRC, 0, 0);
    for (int k = 0; k < 6; k++) begin
      lf = lfsr(lf);
      acc(1, `ACTC_ADDR_DEMAND, lf % 101, 0);
      settle(model(lf % 101));
    end
    acc(1, `ACTC_ADDR_DEMAND, 3, 0);
    settle(model(3));
    pos_unit = 0;
    acc(1, `ACTC_ADDR_DEMAND, 50, 0);
    settle(model(50));
    acc(1, `ACTC_ADDR_DEMAND, 49, 0);
    settle(model(49));
    pos_unit = 1;
    $display("test demand done");
    acc(1, `ACTC_ADDR_DEMAND, 30, 0);
    settle(30);
    acc(1, `ACTC_ADDR_CAL, 1, 0);
    repeat (2) @(negedge core_clk);
    chk(cal_busy, 1);
    acc(1, `ACTC_ADDR_DEMAND, 40, 0);
    settle(100);
    settle(0);
    chk(cal_busy, 0);
    settle(40);
    $display("test calibrate done");
    jam = 1;
    acc(1, `ACTC_ADDR_DEMAND, 80, 0);
    for (i = 0; i < 200 && !stall_fault; i++)
      @(negedge core_clk);
    chk({stall_fault, motor_open, motor_close}, 3'b100);
    jam = 0;
    acc(1, `ACTC_ADDR_DEMAND, 82, 0);
    repeat (20) @(negedge core_clk);
    chk({stall_fault, motor_open, position_pct}, 9'h128);
    acc(1, `ACTC_ADDR_DEMAND, 90, 0);
    settle(90);
    chk(stall_fault, 0);
    $display("test stall done");
    // Second power-up: local dual contacts, then local analog
    pos_unit = 0;
    reset_n = 0;
    repeat (3) @(negedge core_clk);
    reset_n = 1;
    open_c = 1;
    repeat (30) @(negedge core_clk);
    chk({motor_open, motor_close, cal_busy, position_pct}, 10'h000);
    open_c = 0;
    close_c = 1;
    settle(100);
    settle(0);
    chk(cal_busy, 0);
    $display("test power-up done");
    pos_unit = 1;
    analog = 16'h8000;
    settle((32'h8000 - `ACTC_RST_LOW_EP) * 100 /
           (`ACTC_RST_HIGH_EP - `ACTC_RST_LOW_EP));
    acc(0, `ACTC_ADDR_READING, 0, 0);
    chk(rd, analog);
    acc(1, `ACTC_ADDR_LOWCAP, 1, 0);
    settle(0);
    acc(1, `ACTC_ADDR_LOS, 20, 0);
    analog = 16'h0000;
    settle(20);
    $display("test analog done");
    tally_and_finish();
  end
endmodule
